// [common/spi_order_pkg.sv]
// constants shared by both ends of the serial control link
// assumes a 25 MHz system clock on both ends
package spi_order_pkg;
	localparam int INSTR_BITS = 16;
	localparam int ADDR_BITS = 13;
	localparam int BYTE_BITS = 8;
	// instruction field positions
	localparam int RW_POS = 15;
	localparam int LEN_HI_POS = 14;
	localparam int LEN_LO_POS = 13;
	// configuration register holding the bit order flag
	localparam logic [12:0] CFG_ADDR = 13'h0000;
	localparam int LSB_FIRST_POS = 6;
	localparam logic [7:0] CFG_RESET = 8'h10;
	localparam logic [12:0] ADDR_LOW_END = 13'h0000;
	localparam logic [12:0] ADDR_HIGH_END = 13'h1fff;
	// serial clock timing
	localparam int SYS_PERIOD_NS = 40;
	localparam int SCLK_HALF_NS = 160;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [7:0] REG_DEFAULT = 8'h00;
endpackage

// [common/spi_order_if.sv]
// four-wire serial link between host and device
// assumes the bench resolves nothing: all wires are one-way
`timescale 1ns/1ps
interface spi_order_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic serial_data_output;
	logic sdo_oe;
	modport dev (input sclk, input cs_n, input sdi, output serial_data_output, output sdo_oe);
	modport host (output sclk, output cs_n, output sdi, input serial_data_output, input sdo_oe);
endinterface

// [rtl/spi_order_dev.sv]
// device end: instruction decode, bit order, address stepping, register store
// assumes link pins are asynchronous to CLK_SYS and sclk is slow enough to oversample
//
// Function
// - msb first default, bit 6 selects lsb
// - order change applies at once
// - msb mode host sends msb first
// - msb mode host starts at top address
// - msb mode address decrements per byte
// - lsb mode host sends lsb first
// - lsb mode host starts at bottom address
// - lsb mode address increments per byte
// - unused addresses are not skipped
// - rw, length, 13-bit address instruction
// - length code selects one to four bytes; this end ignores it, chip select rise ends the frame
// - host drives address bits 12-7 zero
// - sample rising edge, drive falling edge
`timescale 1ns/1ps
module spi_order_dev #(
	parameter int DEPTH = 128
) (
	// system
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// link
	spi_order_if.dev LINK,
	// status
	output logic LSB_FIRST,
	output logic WR_STROBE,
	output logic [12:0] WR_ADDR,
	output logic [7:0] WR_DATA
);
	typedef enum {ST_IDLE, ST_INSTR, ST_DATA} state_type;
	state_type state_ff;
	logic [2:0] sclk_sy_ff, cs_sy_ff;
	logic [1:0] sdi_sy_ff;
	logic [15:0] shift_ff;
	logic [4:0] cnt_ff;
	logic rw_ff;
	logic [12:0] addr_ff;
	logic [7:0] rd_ff;
	logic lsb_ff;
	logic sdo_ff;
	logic [7:0] mem [DEPTH];
	logic rise, fall, cs_act, sdi_s, last_bit;
	logic [15:0] nxt_shift;
	logic [7:0] byte_in;

	// two-flop synchronisers; edges judged on stages two and three only
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			sclk_sy_ff <= 3'h0;
			cs_sy_ff <= 3'h7;
			sdi_sy_ff <= 2'h0;
		end
		else
		begin
			sclk_sy_ff <= {sclk_sy_ff[1:0], LINK.sclk};
			cs_sy_ff <= {cs_sy_ff[1:0], LINK.cs_n};
			sdi_sy_ff <= {sdi_sy_ff[0], LINK.sdi};
		end
	end
	assign rise = sclk_sy_ff[1] & ~sclk_sy_ff[2];
	assign fall = ~sclk_sy_ff[1] & sclk_sy_ff[2];
	assign cs_act = ~cs_sy_ff[1];
	assign sdi_s = sdi_sy_ff[1];

	// shift toward the end the current order fills from
	always_comb
	begin
		if (lsb_ff)
			nxt_shift = {sdi_s, shift_ff[15:1]};
		else
			nxt_shift = {shift_ff[14:0], sdi_s};
		byte_in = lsb_ff ? nxt_shift[15:8] : nxt_shift[7:0];
		last_bit = (cnt_ff == 5'h07);
	end

	// frame sequencer; a frame ends only when chip select rises
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_ff <= ST_IDLE;
			shift_ff <= 16'h0000;
			cnt_ff <= 5'h00;
			rw_ff <= 1'b0;
			addr_ff <= 13'h0000;
		end
		else if (!cs_act)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= 5'h00;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					state_ff <= ST_INSTR;
					cnt_ff <= 5'h00;
				end
				ST_INSTR:
				begin
					if (rise)
					begin
						shift_ff <= nxt_shift;
						if (cnt_ff == 5'h0f)
						begin
							// length field not needed: cs rise ends transfer
							rw_ff <= nxt_shift[spi_order_pkg::RW_POS];
							addr_ff <= nxt_shift[12:0];
							state_ff <= ST_DATA;
							cnt_ff <= 5'h00;
						end
						else
							cnt_ff <= cnt_ff + 5'h01;
					end
				end
				ST_DATA:
				begin
					if (rise)
					begin
						shift_ff <= nxt_shift;
						cnt_ff <= last_bit ? 5'h00 : cnt_ff + 5'h01;
						// no skipping of unused addresses
						if (last_bit && lsb_ff)
							addr_ff <= addr_ff + 13'h0001;
						else if (last_bit)
							addr_ff <= addr_ff - 13'h0001;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// register writes; config bit 6 changes the order without any update
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			lsb_ff <= spi_order_pkg::CFG_RESET[spi_order_pkg::LSB_FIRST_POS];
			WR_STROBE <= 1'b0;
			WR_ADDR <= 13'h0000;
			WR_DATA <= 8'h00;
		end
		else
		begin
			WR_STROBE <= 1'b0;
			if (cs_act && state_ff == ST_DATA && rise && last_bit && !rw_ff)
			begin
				WR_STROBE <= 1'b1;
				WR_ADDR <= addr_ff;
				WR_DATA <= byte_in;
				if (addr_ff == spi_order_pkg::CFG_ADDR)
					lsb_ff <= byte_in[spi_order_pkg::LSB_FIRST_POS];
			end
		end
	end

	// storage for the low address range; upper address bits are ignored
	always_ff @(posedge CLK_SYS)
	begin
		if (cs_act && state_ff == ST_DATA && rise && last_bit && !rw_ff)
			mem[addr_ff[6:0]] <= byte_in;
	end

	// read data: load a byte at each byte start, shift out on falling edges
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rd_ff <= 8'h00;
			sdo_ff <= 1'b0;
		end
		else if (cs_act && state_ff == ST_DATA && rw_ff && fall)
		begin
			if (cnt_ff == 5'h00)
			begin
				rd_ff <= mem[addr_ff[6:0]];
				sdo_ff <= lsb_ff ? mem[addr_ff[6:0]][0] : mem[addr_ff[6:0]][7];
			end
			else
			begin
				sdo_ff <= lsb_ff ? rd_ff[cnt_ff[2:0]] : rd_ff[3'h7 - cnt_ff[2:0]];
			end
		end
	end

	// output drives only while a read frame is open
	assign LINK.serial_data_output = sdo_ff;
	assign LINK.sdo_oe = cs_act && state_ff == ST_DATA && rw_ff;
	assign LSB_FIRST = lsb_ff;
endmodule

// [rtl/spi_order_host.sv]
// host end: frames one instruction plus up to four data bytes
// assumes the device samples on rising and drives on falling sclk
`timescale 1ns/1ps
module spi_order_host #(
	parameter int HALF = spi_order_pkg::SCLK_HALF_CYC
) (
	// system
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// request
	input wire logic START,
	input wire logic RW,
	input wire logic [1:0] LEN,
	input wire logic [12:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic LSB_MODE,
	output logic BUSY,
	output logic DONE,
	output logic [31:0] RDATA,
	// link
	spi_order_if.host LINK
);
	typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_END} state_type;
	state_type state_ff;
	logic [7:0] div_ff;
	logic [5:0] bit_ff, nbits_ff;
	logic [47:0] tx_ff;
	logic lsb_ff, sclk_ff, cs_ff, sdi_ff, done_ff;
	logic [31:0] rx_ff;
	logic [1:0] sdo_sy_ff;
	logic tick;

	// word position of data bit k; byte 0 of the frame is the top byte in either order
	function automatic logic [4:0] data_pos(input logic [4:0] k, input logic lsb);
		if (lsb)
			return {2'h3 - k[4:3], k[2:0]};
		else
			return 5'h1f - k;
	endfunction

	// half-period enable pulse from a divider
	assign tick = (div_ff == 8'(HALF - 1));
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			div_ff <= 8'h00;
		else
			div_ff <= (tick || state_ff == ST_IDLE) ? 8'h00 : div_ff + 8'h01;
	end

	// sampled read data from outside domain
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			sdo_sy_ff <= 2'h0;
		else
			sdo_sy_ff <= {sdo_sy_ff[0], LINK.serial_data_output};
	end

	// frame sequencer; host places MSB-end address in msb mode
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_ff <= ST_IDLE;
			sclk_ff <= 1'b0;
			cs_ff <= 1'b1;
			sdi_ff <= 1'b0;
			bit_ff <= 6'h00;
			nbits_ff <= 6'h00;
			tx_ff <= 48'h0;
			lsb_ff <= 1'b0;
			rx_ff <= 32'h0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			case (state_ff)
				ST_IDLE:
				begin
					if (START)
					begin
						// top six address bits forced low
						tx_ff <= {RW, LEN, 6'h00, ADDR[6:0], WDATA[31:0]};
						nbits_ff <= 6'(16 + 8 * (LEN + 1));
						lsb_ff <= LSB_MODE;
						// short reads must not show bits of an earlier frame
						rx_ff <= 32'h0;
						bit_ff <= 6'h00;
						cs_ff <= 1'b0;
						state_ff <= ST_LOW;
					end
				end
				ST_LOW:
				begin
					// data set at the start of the low phase so it settles before the rise
					// limitation: with a half period of one cycle data and rise coincide
					if (div_ff == 8'h00)
					begin
						if (lsb_ff && bit_ff < 6'h10)
							sdi_ff <= tx_ff[32 + bit_ff];
						else if (bit_ff < 6'h10)
							sdi_ff <= tx_ff[6'd47 - bit_ff];
						else
							sdi_ff <= tx_ff[data_pos(5'(bit_ff - 6'h10), lsb_ff)];
					end
					if (tick)
					begin
						sclk_ff <= 1'b1;
						state_ff <= ST_HIGH;
					end
				end
				ST_HIGH:
				begin
					if (tick)
					begin
						sclk_ff <= 1'b0;
						// read bits land where the matching write byte came from
						if (bit_ff >= 6'h10)
							rx_ff[data_pos(5'(bit_ff - 6'h10), lsb_ff)] <= sdo_sy_ff[1];
						bit_ff <= bit_ff + 6'h01;
						state_ff <= (bit_ff + 6'h01 == nbits_ff) ? ST_END : ST_LOW;
					end
				end
				ST_END:
				begin
					if (tick)
					begin
						cs_ff <= 1'b1;
						done_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	assign LINK.sclk = sclk_ff;
	assign LINK.cs_n = cs_ff;
	assign LINK.sdi = sdi_ff;
	assign BUSY = state_ff != ST_IDLE;
	assign DONE = done_ff;
	assign RDATA = rx_ff;
endmodule

// [tb/spi_order_props.sv]
// checker of the link wires between the host and device ends
// assumes sclk idles low and both ends run on CLK_SYS
`timescale 1ns/1ps
module spi_order_props (
	// system
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic serial_data_output,
	input wire logic sdo_oe
);
	logic sclk_q_ff, cs_q_ff;
	logic [5:0] rise_cnt_ff;
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	// rising sclk edges per frame, kept until the next select: the device sees cs_n late
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			sclk_q_ff <= 1'b0;
			cs_q_ff <= 1'b1;
			rise_cnt_ff <= 6'h00;
		end
		else
		begin
			sclk_q_ff <= sclk;
			cs_q_ff <= cs_n;
			if (!cs_n && cs_q_ff)
				rise_cnt_ff <= 6'h00;
			else if (!cs_n && sclk && !sclk_q_ff)
				rise_cnt_ff <= rise_cnt_ff + 6'h01;
		end
	end
	// device output enable may trail the deselect by its two synchroniser stages
	a_oe_in_read: assert property (sdo_oe |-> (!cs_n || !$past(cs_n, 2))
		&& rise_cnt_ff >= 6'h10)
		else $error("sdo driven outside the data phase");
	a_clock_in_frame: assert property (sclk |-> !cs_n)
		else $error("sclk high while deselected");
	a_sdi_held_high: assert property (sclk && $past(sclk) && !cs_n |-> $stable(sdi))
		else $error("sdi moved while sclk high");
	a_sdo_held_high: assert property (sclk && $past(sclk) && sdo_oe && $past(sdo_oe)
		|-> $stable(serial_data_output))
		else $error("sdo moved while sclk high");
	a_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("sclk high phase not four cycles");
	a_low_phase: assert property ($fell(sclk) && !cs_n |-> !sclk [*4])
		else $error("sclk low phase too short");
	a_frame_bytes: assert property ($rose(cs_n) |-> rise_cnt_ff >= 6'h18
		&& rise_cnt_ff <= 6'h30 && rise_cnt_ff[2:0] == 3'h0)
		else $error("frame not instruction plus whole bytes");
	a_end_after_low: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
		else $error("deselect before sclk settled low");
endmodule

// [tb/testbench.sv]
// self-checking bench: host and device ends joined over the link
// assumes 25 MHz clock and the default half period of four cycles
`timescale 1ns/1ps
module testbench;
	logic clk_sys, rstn, start, rw, lsb_mode, busy, done, lsb_first, wr_strobe, lsb;
	logic [1:0] len;
	logic [12:0] addr, wr_addr, a;
	logic [31:0] wdata, rdata;
	logic [7:0] wr_data;
	logic [7:0] mem [128];
	logic [31:0] wq [$];
	int seed = 69, err_count = 0, checked = 0, r;
	spi_order_if lnk();
	spi_order_host i_spi_order_host (.CLK_SYS(clk_sys), .RSTN(rstn), .START(start), .RW(rw),
		.LEN(len), .ADDR(addr), .WDATA(wdata), .LSB_MODE(lsb_mode), .BUSY(busy), .DONE(done),
		.RDATA(rdata), .LINK(lnk.host));
	spi_order_dev i_spi_order_dev (.CLK_SYS(clk_sys), .RSTN(rstn), .LINK(lnk.dev),
		.LSB_FIRST(lsb_first), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
	spi_order_props i_spi_order_props (.CLK_SYS(clk_sys), .RSTN(rstn), .sclk(lnk.sclk),
		.cs_n(lnk.cs_n), .sdi(lnk.sdi), .serial_data_output(lnk.serial_data_output), .sdo_oe(lnk.sdo_oe));
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// strobes sampled at the quiet edge to avoid races
	always @(negedge clk_sys)
		if (wr_strobe === 1'b1)
			wq.push_back({11'h000, wr_addr, wr_data});
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// address of byte k: down in msb order, up in lsb order
	function automatic logic [12:0] step(input logic [12:0] b, input int k);
		return lsb ? b + 13'(k) : b - 13'(k);
	endfunction
	task automatic xfer(input logic r_w, input logic [1:0] n, input logic [12:0] b,
		input logic [31:0] d);
		logic [31:0] exp;
		logic [12:0] ea;
		@(negedge clk_sys);
		start = 1'b1;
		rw = r_w;
		len = n;
		addr = b;
		wdata = d;
		lsb_mode = lsb;
		@(negedge clk_sys);
		start = 1'b0;
		chk({31'h0, busy}, 32'h1);
		repeat (2000)
		begin
			@(negedge clk_sys);
			if (done === 1'b1)
				break;
		end
		chk({31'h0, done}, 32'h1);
		chk({31'h0, busy}, 32'h0);
		chk(32'(wq.size()), r_w ? 32'h0 : 32'(n) + 32'h1);
		exp = 32'h0;
		for (int k = 0; k <= int'(n); k++)
		begin
			ea = step(b, k);
			if (r_w)
				exp[31 - 8 * k -: 8] = mem[ea[6:0]];
			else if (wq.size() > 0)
			begin
				chk(wq.pop_front(), {11'h000, ea, d[31 - 8 * k -: 8]});
				mem[ea[6:0]] = d[31 - 8 * k -: 8];
			end
		end
		// order flag follows a write to the config byte at once
		if (!r_w && b == spi_order_pkg::CFG_ADDR)
			lsb = d[24 + spi_order_pkg::LSB_FIRST_POS];
		if (r_w)
			chk(rdata, exp);
		chk({31'h0, lsb_first}, {31'h0, lsb});
	endtask
	initial
	begin
		rstn = 1'b0;
		start = 1'b0;
		rw = 1'b0;
		len = 2'h0;
		addr = 13'h0000;
		wdata = 32'h0;
		lsb_mode = 1'b0;
		lsb = 1'b0;
		foreach (mem[i])
			mem[i] = spi_order_pkg::REG_DEFAULT;
		repeat (20) @(negedge clk_sys);
		rstn = 1'b1;
		@(negedge clk_sys);
		// pass 0 in msb order, pass 1 in lsb order; four-byte case at the ends
		for (int p = 0; p < 2; p++)
		begin
			for (int n = 0; n < 4; n++)
			begin
				r = $random(seed);
				a = (lsb ? 13'h0001 : 13'h0004) + 13'(r[6:0] % 7'h7c);
				if (n == 3)
					a = lsb ? 13'h007c : 13'h0004;
				xfer(1'b0, 2'(n), a, $random(seed));
			end
			xfer(1'b1, 2'h3, a, 32'h0);
			xfer(1'b0, 2'h0, 13'h0000, p == 0 ? 32'h40000000 : 32'h0);
		end
		give_verdict();
	end
	// hang guard: twelve frames need well under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		give_verdict();
	end
endmodule
